/* File: design/fgpio_top.v */
// fast gpio ports with masked access, legacy copies and edge wakeup
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "fgpio_map.vh"
// Notes on behaviour
// - each free pin is input or output, chosen per bit by software
// - separate set and clear registers change any group of outputs at once
// - output register and sensed pin levels are both readable
// - per-port mask limits fast-region reads and writes; masked bits keep outputs there, legacy writes ignore it
// - byte, halfword and word accesses touch only addressed lanes
// - one write loads a whole port output value
// - port 0 and 2 pins interrupt on rise, fall or both unless analog
// - edge detection is asynchronous and works with no clock
// - enabled edge interrupts wake the chip from power-down
// - after reset all pins are inputs with drivers off
// - ports 0 and 1 also appear at legacy register locations
// - edge requests merge with external interrupt line three
module fgpio_top #(
   parameter NPORTS = 5,
   parameter PORT_W = 32
) (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire [`FGPIO_ADDR_W-1:0] addr_i,
   input wire [31:0] wdata_i,
   input wire [3:0] be_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   input wire [NPORTS*PORT_W-1:0] gpio_i,
   output reg [NPORTS*PORT_W-1:0] gpio_o,
   output reg [NPORTS*PORT_W-1:0] gpio_oe_o,
   input wire [2*PORT_W-1:0] analog_sel_i,
   input wire external_interrupt_line_three_i,
   output reg irq_o,
   output wire wake_o
);
   localparam EW = 2 * PORT_W;
   localparam NW = NPORTS * PORT_W;

   reg [PORT_W-1:0] dir_q [0:NPORTS-1];
   reg [PORT_W-1:0] mask_q [0:NPORTS-1];
   reg [PORT_W-1:0] out_q [0:NPORTS-1];
   reg [NW-1:0] sync1_q;
   reg [NW-1:0] sync2_q;
   reg [NW-1:0] sync3_q;
   reg [NW-1:0] pin_q;
   reg [EW-1:0] en_r_q;
   reg [EW-1:0] en_f_q;
   reg [EW-1:0] stat_r_q;
   reg [EW-1:0] stat_f_q;
   reg [EW-1:0] rs1_q;
   reg [EW-1:0] rs2_q;
   reg [EW-1:0] rs3_q;
   reg [EW-1:0] fs1_q;
   reg [EW-1:0] fs2_q;
   reg [EW-1:0] fs3_q;
   reg [EW-1:0] rseen_q;
   reg [EW-1:0] fseen_q;
   reg [31:0] rdata_d;
   wire [EW-1:0] edge_pins;
   wire [EW-1:0] rise_tog;
   wire [EW-1:0] fall_tog;
   wire [EW-1:0] rise_evt;
   wire [EW-1:0] fall_evt;
   wire [EW-1:0] arm_r;
   wire [EW-1:0] arm_f;
   wire [31:0] lane_m;
   wire [1:0] region;
   wire [2:0] fport;
   wire [2:0] freg;
   wire lport;
   wire [1:0] lreg;
   wire egrp;
   wire [1:0] ereg;
   wire esum;
   wire [PORT_W-1:0] fmask;
   wire [PORT_W-1:0] fpins;
   wire [PORT_W-1:0] lpins;
   wire fport_ok;
   wire fast_hit;
   wire leg_hit;
   wire edge_hit;
   wire acc_ok;
   wire [NW-1:0] gpio_d;
   wire [NW-1:0] gpio_oe_d;
   integer p;

   // lane mask from byte enables
   assign lane_m = {{8{be_i[3]}}, {8{be_i[2]}}, {8{be_i[1]}}, {8{be_i[0]}}};
   assign region = addr_i[`FGPIO_REGION_MSB:`FGPIO_REGION_LSB];
   assign fport = addr_i[`FGPIO_FAST_PORT_MSB:`FGPIO_FAST_PORT_LSB];
   assign freg = addr_i[`FGPIO_FAST_REG_MSB:`FGPIO_FAST_REG_LSB];
   assign lport = addr_i[`FGPIO_LEG_PORT_BIT];
   assign lreg = addr_i[`FGPIO_LEG_REG_MSB:`FGPIO_LEG_REG_LSB];
   assign egrp = addr_i[`FGPIO_EDGE_GRP_BIT];
   assign ereg = addr_i[`FGPIO_EDGE_REG_MSB:`FGPIO_EDGE_REG_LSB];
   assign esum = addr_i[`FGPIO_EDGE_SUM_BIT];
   assign fport_ok = ({29'h0000_0000, fport} < NPORTS);
   assign fmask = fport_ok ? mask_q[fport] : {PORT_W{1'b1}};
   assign fpins = fport_ok ? pin_q[fport*PORT_W +: PORT_W] : {PORT_W{1'b0}};
   assign lpins = pin_q[lport*PORT_W +: PORT_W];
   // unused upper address bits must be zero, so those aliases read 0 and drop writes
   assign fast_hit = (region == `FGPIO_REGION_FAST)
      && ~|addr_i[`FGPIO_FAST_TOP_MSB:`FGPIO_FAST_TOP_LSB];
   assign leg_hit = (region == `FGPIO_REGION_LEGACY)
      && ~|addr_i[`FGPIO_LEG_TOP_MSB:`FGPIO_LEG_TOP_LSB];
   assign edge_hit = (region == `FGPIO_REGION_EDGE)
      && ~|addr_i[`FGPIO_EDGE_TOP_MSB:`FGPIO_EDGE_TOP_LSB];
   assign acc_ok = fast_hit | leg_hit | edge_hit;

   // pin synchroniser: a change counts once stages two and three agree
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= {NW{1'b0}};
         sync2_q <= {NW{1'b0}};
         sync3_q <= {NW{1'b0}};
         pin_q <= {NW{1'b0}};
      end else begin
         sync1_q <= gpio_i;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         pin_q <= (~(sync2_q ^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & pin_q);
      end
   end

   // edge capture on ports 0 and 2
   assign edge_pins = {gpio_i[`FGPIO_EDGE_PORT_B*PORT_W +: PORT_W],
                       gpio_i[`FGPIO_EDGE_PORT_A*PORT_W +: PORT_W]};
   assign arm_r = en_r_q & ~analog_sel_i;
   assign arm_f = en_f_q & ~analog_sel_i;

   fgpio_edge_cell #(
      .W(EW)
   ) u_edge (
      .rst_n_i(rst_n_i),
      .pin_i(edge_pins),
      .rise_en_i(arm_r),
      .fall_en_i(arm_f),
      .rise_tog_o(rise_tog),
      .fall_tog_o(fall_tog)
   );

   // toggles cross into the clock domain as events
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rs1_q <= `FGPIO_RST_EDGE;
         rs2_q <= `FGPIO_RST_EDGE;
         rs3_q <= `FGPIO_RST_EDGE;
         fs1_q <= `FGPIO_RST_EDGE;
         fs2_q <= `FGPIO_RST_EDGE;
         fs3_q <= `FGPIO_RST_EDGE;
         rseen_q <= `FGPIO_RST_EDGE;
         fseen_q <= `FGPIO_RST_EDGE;
      end else begin
         rs1_q <= rise_tog;
         rs2_q <= rs1_q;
         rs3_q <= rs2_q;
         fs1_q <= fall_tog;
         fs2_q <= fs1_q;
         fs3_q <= fs2_q;
         rseen_q <= rseen_q ^ rise_evt;
         fseen_q <= fseen_q ^ fall_evt;
      end
   end
   assign rise_evt = ~(rs2_q ^ rs3_q) & (rs3_q ^ rseen_q);
   assign fall_evt = ~(fs2_q ^ fs3_q) & (fs3_q ^ fseen_q);

   // pending edge not yet seen by the clocked side raises wake
   assign wake_o = |((rise_tog ^ rseen_q) | (fall_tog ^ fseen_q));

   // register writes
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (p = 0; p < NPORTS; p = p + 1) begin
            dir_q[p] <= `FGPIO_RST_WORD;
            mask_q[p] <= `FGPIO_RST_WORD;
            out_q[p] <= `FGPIO_RST_WORD;
         end
      end else if (wr_i && acc_ok) begin
         case (region)
            `FGPIO_REGION_FAST: begin
               if (fport_ok) begin
                  case (freg)
                     `FGPIO_FAST_DIR: begin
                        dir_q[fport] <= (dir_q[fport] & ~lane_m) | (wdata_i & lane_m);
                     end
                     `FGPIO_FAST_MASK: begin
                        mask_q[fport] <= (mask_q[fport] & ~lane_m) | (wdata_i & lane_m);
                     end
                     `FGPIO_FAST_PIN: begin
                        // whole port value, masked bits kept
                        out_q[fport] <= (out_q[fport] & ~(lane_m & ~fmask))
                           | (wdata_i & lane_m & ~fmask);
                     end
                     `FGPIO_FAST_SET: begin
                        out_q[fport] <= out_q[fport] | (wdata_i & lane_m & ~fmask);
                     end
                     `FGPIO_FAST_CLR: begin
                        out_q[fport] <= out_q[fport] & ~(wdata_i & lane_m & ~fmask);
                     end
                     default: begin
                     end
                  endcase
               end
            end
            `FGPIO_REGION_LEGACY: begin
               // legacy copies of ports 0 and 1, unmasked
               case (lreg)
                  `FGPIO_LEG_SET: begin
                     out_q[lport] <= out_q[lport] | (wdata_i & lane_m);
                  end
                  `FGPIO_LEG_CLR: begin
                     out_q[lport] <= out_q[lport] & ~(wdata_i & lane_m);
                  end
                  `FGPIO_LEG_DIR: begin
                     dir_q[lport] <= (dir_q[lport] & ~lane_m) | (wdata_i & lane_m);
                  end
                  default: begin
                  end
               endcase
            end
            default: begin
            end
         endcase
      end
   end

   // edge enables and sticky status, set wins over clear
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_r_q <= `FGPIO_RST_EDGE;
         en_f_q <= `FGPIO_RST_EDGE;
         stat_r_q <= `FGPIO_RST_EDGE;
         stat_f_q <= `FGPIO_RST_EDGE;
      end else begin
         if (wr_i && edge_hit && !esum) begin
            case (ereg)
               `FGPIO_EDGE_STAT_R: begin
                  // other group keeps its events, addressed slice overrides
                  stat_r_q <= stat_r_q | rise_evt;
                  stat_r_q[egrp*PORT_W +: PORT_W] <= (stat_r_q[egrp*PORT_W +: PORT_W]
                     & ~(wdata_i & lane_m)) | rise_evt[egrp*PORT_W +: PORT_W];
                  stat_f_q <= stat_f_q | fall_evt;
               end
               `FGPIO_EDGE_STAT_F: begin
                  // other group keeps its events, addressed slice overrides
                  stat_f_q <= stat_f_q | fall_evt;
                  stat_f_q[egrp*PORT_W +: PORT_W] <= (stat_f_q[egrp*PORT_W +: PORT_W]
                     & ~(wdata_i & lane_m)) | fall_evt[egrp*PORT_W +: PORT_W];
                  stat_r_q <= stat_r_q | rise_evt;
               end
               `FGPIO_EDGE_EN_R: begin
                  en_r_q[egrp*PORT_W +: PORT_W] <= (en_r_q[egrp*PORT_W +: PORT_W] & ~lane_m)
                     | (wdata_i & lane_m);
                  stat_r_q <= stat_r_q | rise_evt;
                  stat_f_q <= stat_f_q | fall_evt;
               end
               default: begin
                  en_f_q[egrp*PORT_W +: PORT_W] <= (en_f_q[egrp*PORT_W +: PORT_W] & ~lane_m)
                     | (wdata_i & lane_m);
                  stat_r_q <= stat_r_q | rise_evt;
                  stat_f_q <= stat_f_q | fall_evt;
               end
            endcase
         end else begin
            stat_r_q <= stat_r_q | rise_evt;
            stat_f_q <= stat_f_q | fall_evt;
         end
      end
   end

   // read mux
   always @* begin
      rdata_d = `FGPIO_RST_WORD;
      case (region)
         `FGPIO_REGION_FAST: begin
            if (fport_ok) begin
               case (freg)
                  `FGPIO_FAST_DIR: rdata_d = dir_q[fport];
                  `FGPIO_FAST_MASK: rdata_d = mask_q[fport];
                  `FGPIO_FAST_PIN: rdata_d = fpins & ~fmask;
                  `FGPIO_FAST_SET: rdata_d = out_q[fport] & ~fmask;
                  default: rdata_d = `FGPIO_RST_WORD;
               endcase
            end
         end
         `FGPIO_REGION_LEGACY: begin
            case (lreg)
               `FGPIO_LEG_PIN: rdata_d = lpins;
               `FGPIO_LEG_SET: rdata_d = out_q[lport];
               `FGPIO_LEG_DIR: rdata_d = dir_q[lport];
               default: rdata_d = `FGPIO_RST_WORD;
            endcase
         end
         `FGPIO_REGION_EDGE: begin
            if (esum) begin
               rdata_d = {30'h0000_0000,
                  |((stat_r_q[EW-1:PORT_W] & en_r_q[EW-1:PORT_W])
                  | (stat_f_q[EW-1:PORT_W] & en_f_q[EW-1:PORT_W])),
                  |((stat_r_q[PORT_W-1:0] & en_r_q[PORT_W-1:0])
                  | (stat_f_q[PORT_W-1:0] & en_f_q[PORT_W-1:0]))};
            end else begin
               case (ereg)
                  `FGPIO_EDGE_STAT_R: rdata_d = stat_r_q[egrp*PORT_W +: PORT_W];
                  `FGPIO_EDGE_STAT_F: rdata_d = stat_f_q[egrp*PORT_W +: PORT_W];
                  `FGPIO_EDGE_EN_R: rdata_d = en_r_q[egrp*PORT_W +: PORT_W];
                  default: rdata_d = en_f_q[egrp*PORT_W +: PORT_W];
               endcase
            end
         end
         default: rdata_d = `FGPIO_RST_WORD;
      endcase
   end

   // per-port flattening of output and direction registers
   genvar gp;
   generate
      for (gp = 0; gp < NPORTS; gp = gp + 1) begin : g_port
         assign gpio_d[gp*PORT_W +: PORT_W] = out_q[gp];
         assign gpio_oe_d[gp*PORT_W +: PORT_W] = dir_q[gp];
      end
   endgenerate

   // registered outputs
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= `FGPIO_RST_WORD;
         gpio_o <= {NW{1'b0}};
         gpio_oe_o <= {NW{1'b0}};
         irq_o <= 1'b0;
      end else begin
         rdata_o <= (rd_i && acc_ok) ? rdata_d : `FGPIO_RST_WORD;
         gpio_o <= gpio_d;
         gpio_oe_o <= gpio_oe_d;
         irq_o <= |((stat_r_q & en_r_q) | (stat_f_q & en_f_q))
            | external_interrupt_line_three_i;
      end
   end
endmodule
`default_nettype wire

/* File: design/fgpio_map.vh */
// register map, field layout and reset values of the fast gpio block
`ifndef FGPIO_MAP_VH
`define FGPIO_MAP_VH
`define FGPIO_ADDR_W 12
`define FGPIO_REGION_MSB 11
`define FGPIO_REGION_LSB 10
`define FGPIO_REGION_FAST 2'h0
`define FGPIO_REGION_LEGACY 2'h1
`define FGPIO_REGION_EDGE 2'h2
`define FGPIO_FAST_TOP_MSB 9
`define FGPIO_FAST_TOP_LSB 8
`define FGPIO_LEG_TOP_MSB 9
`define FGPIO_LEG_TOP_LSB 5
`define FGPIO_EDGE_TOP_MSB 9
`define FGPIO_EDGE_TOP_LSB 6
`define FGPIO_FAST_PORT_MSB 7
`define FGPIO_FAST_PORT_LSB 5
`define FGPIO_FAST_REG_MSB 4
`define FGPIO_FAST_REG_LSB 2
`define FGPIO_FAST_DIR 3'h0
`define FGPIO_FAST_MASK 3'h4
`define FGPIO_FAST_PIN 3'h5
`define FGPIO_FAST_SET 3'h6
`define FGPIO_FAST_CLR 3'h7
`define FGPIO_LEG_PORT_BIT 4
`define FGPIO_LEG_REG_MSB 3
`define FGPIO_LEG_REG_LSB 2
`define FGPIO_LEG_PIN 2'h0
`define FGPIO_LEG_SET 2'h1
`define FGPIO_LEG_DIR 2'h2
`define FGPIO_LEG_CLR 2'h3
`define FGPIO_EDGE_GRP_BIT 4
`define FGPIO_EDGE_REG_MSB 3
`define FGPIO_EDGE_REG_LSB 2
`define FGPIO_EDGE_SUM_BIT 5
`define FGPIO_EDGE_STAT_R 2'h0
`define FGPIO_EDGE_STAT_F 2'h1
`define FGPIO_EDGE_EN_R 2'h2
`define FGPIO_EDGE_EN_F 2'h3
`define FGPIO_EDGE_PORT_A 0
`define FGPIO_EDGE_PORT_B 2
`define FGPIO_RST_WORD 32'h0000_0000
`define FGPIO_RST_EDGE 64'h0000_0000_0000_0000
`define FGPIO_RST_TWO 2'h0
`endif

/* File: design/fgpio_edge_cell.v */
// asynchronous per-pin edge toggles that run without the system clock
`timescale 1ns/100ps
`default_nettype none
module fgpio_edge_cell #(
   parameter W = 32
) (
   input wire rst_n_i,
   input wire [W-1:0] pin_i,
   input wire [W-1:0] rise_en_i,
   input wire [W-1:0] fall_en_i,
   output wire [W-1:0] rise_tog_o,
   output wire [W-1:0] fall_tog_o
);
   genvar k;
   generate
      for (k = 0; k < W; k = k + 1) begin : g_bit
         reg rise_q;
         reg fall_q;
         // pin edge clocks the toggle, no system clock needed
         always @(posedge pin_i[k] or negedge rst_n_i) begin
            if (!rst_n_i) begin
               rise_q <= 1'b0;
            end else if (rise_en_i[k]) begin
               rise_q <= ~rise_q;
            end
         end
         always @(negedge pin_i[k] or negedge rst_n_i) begin
            if (!rst_n_i) begin
               fall_q <= 1'b0;
            end else if (fall_en_i[k]) begin
               fall_q <= ~fall_q;
            end
         end
         assign rise_tog_o[k] = rise_q;
         assign fall_tog_o[k] = fall_q;
      end
   endgenerate
endmodule
`default_nettype wire

/* File: sim/fgpio_sva.sv */
// port assertions for the fast gpio block
`timescale 1ns/100ps
`default_nettype none
module fgpio_sva #(
   parameter NPORTS = 5,
   parameter PORT_W = 32
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [11:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] be_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic [NPORTS*PORT_W-1:0] gpio_i,
   input wire logic [NPORTS*PORT_W-1:0] gpio_o,
   input wire logic [NPORTS*PORT_W-1:0] gpio_oe_o,
   input wire logic [2*PORT_W-1:0] analog_sel_i,
   input wire logic external_interrupt_line_three_i,
   input wire logic irq_o,
   input wire logic wake_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // full-word write to one legacy register
   sequence s_leg_wr(logic [11:0] a);
      wr_i && addr_i == a && be_i == 4'hf;
   endsequence
   a_reset_inputs: assert property ($rose(rst_n_i) |-> !(|gpio_oe_o) && !(|gpio_o))
      else $error("outputs active after reset");
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside its slot");
   a_out_timing: assert property ($changed(gpio_o) |-> $past(wr_i, 2))
      else $error("outputs moved without a write");
   a_dir_timing: assert property ($changed(gpio_oe_o) |-> $past(wr_i, 2))
      else $error("enables moved without a write");
   a_set_ones: assert property (s_leg_wr(12'h404) |-> ##2
      gpio_o[31:0] == ($past(gpio_o[31:0]) | $past(wdata_i, 2)))
      else $error("set write gave wrong outputs");
   a_clr_ones: assert property (s_leg_wr(12'h40c) |-> ##2
      gpio_o[31:0] == ($past(gpio_o[31:0]) & ~$past(wdata_i, 2)))
      else $error("clear write gave wrong outputs");
   a_dir_load: assert property (s_leg_wr(12'h408) |-> ##2
      gpio_oe_o[31:0] == $past(wdata_i, 2))
      else $error("legacy direction not loaded");
   a_line_three: assert property (external_interrupt_line_three_i |=> irq_o)
      else $error("line three request not on irq");
   a_wake_irq: assert property (wake_o |-> ##[0:8] irq_o)
      else $error("wake without interrupt");
endmodule
bind fgpio_top fgpio_sva #(.NPORTS(NPORTS), .PORT_W(PORT_W)) fgpio_sva_i (.ref_clk_i, .rst_n_i,
   .addr_i, .wdata_i, .be_i, .wr_i, .rd_i, .rdata_o, .gpio_i, .gpio_o, .gpio_oe_o,
   .analog_sel_i, .external_interrupt_line_three_i, .irq_o, .wake_o);
`default_nettype wire

/* File: sim/fgpio_pins.sv */
// pin level model of the circuitry outside the ports
`timescale 1ns/100ps
`default_nettype none
module fgpio_pins #(
   parameter W = 160
) (
   input wire logic [W-1:0] ext_i,
   input wire logic [W-1:0] drv_i,
   input wire logic [W-1:0] oe_i,
   output logic [W-1:0] pin_o
);
   // driven pins show the block value, others the outside level
   assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

/* File: sim/tb_fast_gpio_with_edge_wakeup.sv */
// self-checking bench for the fast gpio block
`timescale 1ns/100ps
`default_nettype none
module tb_fast_gpio_with_edge_wakeup;
   logic clk = 0, run = 1, rst_n = 1, wr = 0, rd = 0, l3 = 0, irq, wake;
   logic [11:0] addr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, out [5], dir [5], msk [5];
   logic [31:0] sr [2], sf [2], er [2], ef [2];
   logic [3:0] be = 4'h0, bt [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
   logic [159:0] ext = 160'h0, pins, gout, goe;
   logic [63:0] an = 64'h0;
   int n_errors = 0, compares = 0;
   always #25 clk = run ? ~clk : clk;
   fgpio_pins fgpio_pins_i (.ext_i(ext), .drv_i(gout), .oe_i(goe), .pin_o(pins));
   fgpio_top fgpio_top_i (.ref_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
      .be_i(be), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .gpio_i(pins), .gpio_o(gout),
      .gpio_oe_o(goe), .analog_sel_i(an), .external_interrupt_line_three_i(l3),
      .irq_o(irq), .wake_o(wake));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task finish_test;
      if (n_errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   function logic [31:0] pin_m(input int p);
      return (out[p] & dir[p]) | (ext[32*p+:32] & ~dir[p]);
   endfunction
   function logic irq_m;
      return |((sr[0] & er[0]) | (sf[0] & ef[0]) | (sr[1] & er[1]) | (sf[1] & ef[1])) | l3;
   endfunction
   function logic [31:0] exp_rd(input logic [11:0] a);
      int p, g;
      p = a[7:5];
      g = a[4];
      if (a[11:10] == 2'h0 && a[9:8] == 2'h0 && p < 5)
         case (a[4:2])
            3'h0: return dir[p];
            3'h4: return msk[p];
            3'h5: return pin_m(p) & ~msk[p];
            3'h6: return out[p] & ~msk[p];
         endcase
      if (a[11:10] == 2'h1 && a[9:5] == 5'h0)
         case (a[3:2])
            2'h0: return pin_m(g);
            2'h1: return out[g];
            2'h2: return dir[g];
         endcase
      if (a[11:10] == 2'h2 && a[9:5] == 5'h01)
         return {30'h0, |((sr[1] & er[1]) | (sf[1] & ef[1])),
            |((sr[0] & er[0]) | (sf[0] & ef[0]))};
      if (a[11:10] == 2'h2 && a[9:5] == 5'h0)
         case (a[3:2])
            2'h0: return sr[g];
            2'h1: return sf[g];
            2'h2: return er[g];
            2'h3: return ef[g];
         endcase
      return 32'h0;
   endfunction
   task wr_m(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
      logic [31:0] m;
      int p, g;
      m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
      p = a[7:5];
      g = a[4];
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      be <= b;
      @(posedge clk);
      wr <= 1'b0;
      if (a[11:10] == 2'h0 && a[9:8] == 2'h0 && p < 5)
         case (a[4:2])
            3'h0: dir[p] = (dir[p] & ~m) | (d & m);
            3'h4: msk[p] = (msk[p] & ~m) | (d & m);
            3'h5: out[p] = (out[p] & ~(m & ~msk[p])) | (d & m & ~msk[p]);
            3'h6: out[p] = out[p] | (d & m & ~msk[p]);
            3'h7: out[p] = out[p] & ~(d & m & ~msk[p]);
         endcase
      if (a[11:10] == 2'h1 && a[9:5] == 5'h0)
         case (a[3:2])
            2'h1: out[g] = out[g] | (d & m);
            2'h2: dir[g] = (dir[g] & ~m) | (d & m);
            2'h3: out[g] = out[g] & ~(d & m);
         endcase
      if (a[11:10] == 2'h2 && a[9:5] == 5'h0)
         case (a[3:2])
            2'h0: sr[g] = sr[g] & ~(d & m);
            2'h1: sf[g] = sf[g] & ~(d & m);
            2'h2: er[g] = (er[g] & ~m) | (d & m);
            2'h3: ef[g] = (ef[g] & ~m) | (d & m);
         endcase
   endtask
   task rd_c(input logic [11:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp_rd(a));
   endtask
   task cmp_out;
      cyc(3);
      #1;
      for (int p = 0; p < 5; p++) begin
         chk(gout[32*p+:32], out[p]);
         chk(goe[32*p+:32], dir[p]);
      end
   endtask
   task chk_irq;
      #1 chk({31'h0, irq}, {31'h0, irq_m()});
   endtask
   // pin change with edge bookkeeping for ports 0 and 2 held as inputs
   task ext_set(input logic [159:0] v);
      logic [31:0] o, n;
      for (int g = 0; g < 2; g++) begin
         o = ext[64*g+:32];
         n = v[64*g+:32];
         sr[g] = sr[g] | (~o & n & er[g] & ~an[32*g+:32]);
         sf[g] = sf[g] | (o & ~n & ef[g] & ~an[32*g+:32]);
      end
      ext <= v;
   endtask
   task do_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         out[i] = 32'h0;
         dir[i] = 32'h0;
         msk[i] = 32'h0;
      end
      sr = '{32'h0, 32'h0};
      sf = '{32'h0, 32'h0};
      er = '{32'h0, 32'h0};
      ef = '{32'h0, 32'h0};
      cyc(2);
      rst_n <= 1'b1;
      for (int p = 0; p < 5; p++) rd_c(12'(32 * p));
      cmp_out;
   endtask
   initial begin
      #1000000;
      n_errors++;
      finish_test;
   end
   initial begin
      void'($urandom(97));
      rst_n <= 1'b0;
      do_reset;
      repeat (4) begin
         for (int p = 0; p < 5; p++) begin
            wr_m(12'(32 * p), $urandom, bt[$urandom % 7]);
            wr_m(12'(32 * p + 20), $urandom, 4'hf);
            wr_m(12'(32 * p + 16), $urandom, bt[$urandom % 7]);
            wr_m(12'(32 * p + 20), $urandom, bt[$urandom % 7]);
            wr_m(12'(32 * p + 24), $urandom, bt[$urandom % 7]);
            wr_m(12'(32 * p + 28), $urandom, bt[$urandom % 7]);
            cmp_out;
            cyc(6);
            for (int r = 0; r < 4; r++) rd_c(12'(32 * p + (r == 0 ? 0 : 12 + 4 * r)));
         end
         wr_m(12'h408, $urandom, 4'hf);
         wr_m(12'h404, $urandom, 4'hf);
         wr_m(12'h40c, $urandom, 4'hf);
         wr_m(12'h418, $urandom, bt[$urandom % 7]);
         wr_m(12'h0a0, $urandom, 4'hf);
         cmp_out;
         cyc(6);
         for (int r = 0; r < 3; r++) rd_c(12'(12'h400 + 4 * r));
         rd_c(12'h414);
         rd_c(12'h520);
         rd_c(12'h0a0);
         rd_c(12'hc00);
      end
      wr_m(12'h000, 32'h0, 4'hf);
      wr_m(12'h040, 32'h0, 4'hf);
      cyc(8);
      ext_set(160'h1 << 69);
      an <= 64'h10;
      wr_m(12'h808, 32'h58, 4'hf);
      wr_m(12'h80c, 32'h40, 4'hf);
      wr_m(12'h81c, 32'h20, 4'hf);
      cyc(4);
      run = 1'b0;
      #100 ext_set(ext | 160'h58);
      #100 chk({31'h0, wake}, 32'h1);
      run = 1'b1;
      cyc(10);
      chk_irq;
      chk({31'h0, wake}, 32'h0);
      rd_c(12'h800);
      #5 ext_set(ext & ~(160'h40 | (160'h1 << 69)));
      cyc(10);
      rd_c(12'h804);
      rd_c(12'h814);
      rd_c(12'h820);
      wr_m(12'h808, 32'h0, 4'hf);
      wr_m(12'h80c, 32'h0, 4'hf);
      wr_m(12'h81c, 32'h0, 4'hf);
      cyc(3);
      chk_irq;
      rd_c(12'h800);
      wr_m(12'h808, 32'h58, 4'hf);
      cyc(3);
      chk_irq;
      wr_m(12'h800, 32'hffff_ffff, 4'hf);
      cyc(3);
      chk_irq;
      rd_c(12'h800);
      @(posedge clk);
      l3 <= 1'b1;
      cyc(2);
      chk_irq;
      @(posedge clk);
      l3 <= 1'b0;
      cyc(2);
      chk_irq;
      do_reset;
      finish_test;
   end
endmodule
`default_nettype wire
